// File: src/spe_error_flags.sv
// Purpose: per-port link error flag register with event latching
// Assumes: event pulses from link, transport and DMA logic on clock_in;
//          phy_link_up_signal_in comes from a pin and is synchronised
// Notes:   all flags are sticky and cleared by writing one
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps

module spe_error_flags
  import spe_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // PHY pin level
  input  wire logic        phy_link_up_signal_in,
  // Link and transport events
  input  wire logic        presence_change_in,
  input  wire logic        cominit_rx_in,
  input  wire logic        unknown_fis_in,
  input  wire logic        transport_state_err_in,
  input  wire logic        r_err_rx_in,
  input  wire logic        link_crc_err_in,
  input  wire logic        decode_err_in,
  input  wire logic        comwake_rx_in,
  input  wire logic        phy_internal_err_in,
  input  wire logic        mem_abort_in,
  input  wire logic        protocol_err_in,
  input  wire logic        persistent_err_in,
  input  wire logic        transient_err_in,
  input  wire logic        recovered_comm_in,
  input  wire logic        recovered_data_in,
  // Status outputs
  output logic             port_link_error_flags_stop_out,
  output logic             phy_ready_change_irq_status_out,
  output logic             port_connect_change_status_out,
  output logic             irq_out
);

  logic [31:0] port_link_error_flags;
  logic [31:0] next_flags;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [1:0]  irq_enable;
  logic [1:0]  irq_status;
  logic        phy_up_sync;
  logic        phy_up_prev;
  logic        phy_edge;
  logic        xfer_stop;

  // PHY-ready level through two flip-flops
  spe_sync #(
    .WIDTH (1)
  ) u_phy_sync (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .async_in (phy_link_up_signal_in),
    .sync_out (phy_up_sync)
  );

  // Edge history of synchronised PHY-ready
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phy_up_prev <= 1'b0;
    end else begin
      phy_up_prev <= phy_up_sync;
    end
  end

  assign phy_edge = phy_up_sync ^ phy_up_prev;

  // Event to bit mapping
  always_comb begin
    set_vec                     = 32'h0000_0000;
    set_vec[SPE_BIT_EXCHANGED]  = presence_change_in | cominit_rx_in;
    set_vec[SPE_BIT_UNK_FIS]    = unknown_fis_in;
    set_vec[SPE_BIT_TRANSPORT]  = transport_state_err_in;
    set_vec[SPE_BIT_HANDSHAKE]  = r_err_rx_in;
    set_vec[SPE_BIT_LINK_CRC]   = link_crc_err_in;
    set_vec[SPE_BIT_DISPARITY]  = 1'b0;
    set_vec[SPE_BIT_DECODE]     = decode_err_in;
    set_vec[SPE_BIT_COMWAKE]    = comwake_rx_in;
    set_vec[SPE_BIT_PHY_INTERR] = phy_internal_err_in;
    set_vec[SPE_BIT_PHY_CHANGE] = phy_edge;
    set_vec[SPE_BIT_INT_ERR]    = mem_abort_in;
    set_vec[SPE_BIT_PROTOCOL]   = protocol_err_in;
    set_vec[SPE_BIT_PERSIST]    = persistent_err_in;
    set_vec[SPE_BIT_TRANSIENT]  = transient_err_in;
    set_vec[SPE_BIT_RECOV_COMM] = recovered_comm_in;
    set_vec[SPE_BIT_RECOV_DATA] = recovered_data_in;
  end

  // Write-one-clear on the flag register
  assign clr_vec = (reg_write_in && reg_addr_in == SPE_OFS_ERR_FLAGS) ?
                   (reg_wdata_in & SPE_FLAG_MASK) : 32'h0000_0000;

  // Set wins over a clear in the same cycle
  assign next_flags = ((port_link_error_flags & ~clr_vec) | set_vec)
                      & SPE_FLAG_MASK;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      port_link_error_flags <= SPE_RST_FLAGS;
    end else begin
      port_link_error_flags <= next_flags;
    end
  end

  // Interrupt enable register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_enable <= SPE_RST_IRQ_ENABLE;
    end else if (reg_write_in && reg_addr_in == SPE_OFS_IRQ_ENABLE) begin
      irq_enable <= reg_wdata_in[1:0];
    end
  end

  // Status mirrors of the sticky flags
  always_comb begin
    irq_status                     = 2'h0;
    irq_status[SPE_IRQ_PHY_CHANGE] = port_link_error_flags[SPE_BIT_PHY_CHANGE];
    irq_status[SPE_IRQ_CONNECT]    = port_link_error_flags[SPE_BIT_EXCHANGED];
  end

  assign xfer_stop = |(port_link_error_flags & SPE_STOP_MASK);

  // Outputs from registered state
  assign phy_ready_change_irq_status_out = irq_status[SPE_IRQ_PHY_CHANGE];
  assign port_connect_change_status_out  = irq_status[SPE_IRQ_CONNECT];
  assign irq_out                         = |(irq_status & irq_enable);
  assign port_link_error_flags_stop_out  = xfer_stop;

  // Read data one cycle after the read strobe
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        SPE_OFS_ERR_FLAGS:   reg_rdata_out <= port_link_error_flags;
        SPE_OFS_IRQ_STATUS:  reg_rdata_out <= {30'h0000_0000, irq_status};
        SPE_OFS_IRQ_ENABLE:  reg_rdata_out <= {30'h0000_0000, irq_enable};
        SPE_OFS_XFER_STATUS: reg_rdata_out <= {31'h0000_0000, xfer_stop};
        default:             reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule // spe_error_flags

// File: src/spe_pkg.sv
// Purpose: constants for the port link error flag register block
// Assumes: one 32-bit register bank on a plain strobe port
// Notes:   offsets are word indices on the plain port
package spe_pkg;

  // Register offsets
  localparam logic [3:0]  SPE_OFS_ERR_FLAGS   = 4'h0;
  localparam logic [3:0]  SPE_OFS_IRQ_STATUS  = 4'h1;
  localparam logic [3:0]  SPE_OFS_IRQ_ENABLE  = 4'h2;
  localparam logic [3:0]  SPE_OFS_XFER_STATUS = 4'h3;

  // Field positions in the error flag register
  localparam int SPE_BIT_EXCHANGED   = 26;
  localparam int SPE_BIT_UNK_FIS     = 25;
  localparam int SPE_BIT_TRANSPORT   = 24;
  localparam int SPE_BIT_HANDSHAKE   = 22;
  localparam int SPE_BIT_LINK_CRC    = 21;
  localparam int SPE_BIT_DISPARITY   = 20;
  localparam int SPE_BIT_DECODE      = 19;
  localparam int SPE_BIT_COMWAKE     = 18;
  localparam int SPE_BIT_PHY_INTERR  = 17;
  localparam int SPE_BIT_PHY_CHANGE  = 16;
  localparam int SPE_BIT_INT_ERR     = 11;
  localparam int SPE_BIT_PROTOCOL    = 10;
  localparam int SPE_BIT_PERSIST     = 9;
  localparam int SPE_BIT_TRANSIENT   = 8;
  localparam int SPE_BIT_RECOV_COMM  = 1;
  localparam int SPE_BIT_RECOV_DATA  = 0;

  // Writable flag mask (reserved bits and unused bit 20 excluded; unused bit 23 included)
  localparam logic [31:0] SPE_FLAG_MASK       = 32'h07EF_0F03;
  localparam logic [31:0] SPE_STOP_MASK       = 32'h0000_0F00;

  // Interrupt status field positions
  localparam int SPE_IRQ_PHY_CHANGE  = 0;
  localparam int SPE_IRQ_CONNECT     = 1;

  // Reset values
  localparam logic [31:0] SPE_RST_FLAGS       = 32'h0000_0000;
  localparam logic [1:0]  SPE_RST_IRQ_ENABLE  = 2'h0;

  // Event input count
  localparam int SPE_NUM_EVENTS      = 15;

endpackage

// File: src/spe_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: one clock, asynchronous active-low reset
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module spe_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // spe_sync

// File: verif/sata_port_error_status_tb_top.sv
// Purpose: self-checking bench for the link error flag block
// Assumes: 250 MHz clock, reset held 10 cycles
// Notes:   events pulse one cycle, then flags are read back
`timescale 1ns/1ps
module sata_port_error_status_tb_top
  import spe_pkg::*;
;
  logic        clock_in = 0, rst_n_in = 0, rd = 0, wr = 0, tog = 0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, got;
  logic [14:0] ev = 15'h0;
  logic        phy, stp, prc, pcc, irq;
  int          mismatches = 0, num_checks = 0;
  int          bits[15] = '{26, 26, 25, 24, 22, 21, 19, 18, 17, 11, 10, 9, 8, 1, 0};
  initial forever #2 clock_in = ~clock_in;
  spe_drive_model spe_drive_model_inst (.clock_in(clock_in), .toggle_in(tog), .phy_level_out(phy));
  spe_error_flags spe_error_flags_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .phy_link_up_signal_in(phy), .presence_change_in(ev[0]),
    .cominit_rx_in(ev[1]), .unknown_fis_in(ev[2]), .transport_state_err_in(ev[3]),
    .r_err_rx_in(ev[4]), .link_crc_err_in(ev[5]), .decode_err_in(ev[6]),
    .comwake_rx_in(ev[7]), .phy_internal_err_in(ev[8]), .mem_abort_in(ev[9]),
    .protocol_err_in(ev[10]), .persistent_err_in(ev[11]), .transient_err_in(ev[12]),
    .recovered_comm_in(ev[13]), .recovered_data_in(ev[14]),
    .port_link_error_flags_stop_out(stp), .phy_ready_change_irq_status_out(prc),
    .port_connect_change_status_out(pcc), .irq_out(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask
  task automatic r(input logic [3:0] a);
    @(posedge clock_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic flip;
    @(posedge clock_in);
    tog <= 1'b1;
    @(posedge clock_in);
    tog <= 1'b0;
    repeat (6) @(posedge clock_in);
    r(SPE_OFS_ERR_FLAGS);
    chk(got, 32'h0001_0000);
  endtask
  task automatic t_events;
    for (int i = 0; i < 15; i++) begin
      @(posedge clock_in);
      ev <= 15'h1 << i;
      @(posedge clock_in);
      ev <= 15'h0;
      rd <= 1'b1;
      addr <= SPE_OFS_ERR_FLAGS;
      @(posedge clock_in);
      rd <= 1'b0;
      #1 got = rdata;
      chk(got, 32'h1 << bits[i]);
      chk({31'h0, stp}, {31'h0, bits[i] inside {[8:11]}});
      chk({31'h0, pcc}, {31'h0, bits[i] == 26});
      r(SPE_OFS_XFER_STATUS);
      chk(got, {31'h0, bits[i] inside {[8:11]}});
      w(SPE_OFS_ERR_FLAGS, 32'h0);
      r(SPE_OFS_ERR_FLAGS);
      chk(got, 32'h1 << bits[i]);
      w(SPE_OFS_ERR_FLAGS, 32'hFFFF_FFFF);
      r(SPE_OFS_ERR_FLAGS);
      chk(got, 32'h0);
    end
    $display("events test done");
  endtask
  task automatic t_phy;
    w(SPE_OFS_IRQ_ENABLE, 32'h1);
    flip();
    chk({30'h0, prc, irq}, 32'h3);
    r(SPE_OFS_IRQ_STATUS);
    chk(got, 32'h1);
    w(SPE_OFS_ERR_FLAGS, 32'h0);
    #1 chk({31'h0, prc}, 32'h1);
    w(SPE_OFS_ERR_FLAGS, 32'h0001_0000);
    #1 chk({30'h0, prc, irq}, 32'h0);
    flip();
    w(SPE_OFS_ERR_FLAGS, 32'h0001_0000);
    w(SPE_OFS_IRQ_ENABLE, 32'h2);
    r(SPE_OFS_IRQ_ENABLE);
    chk(got, 32'h2);
    @(posedge clock_in);
    ev <= 15'h2;
    @(posedge clock_in);
    ev <= 15'h0;
    #1 chk({30'h0, pcc, irq}, 32'h3);
    r(SPE_OFS_IRQ_STATUS);
    chk(got, 32'h2);
    w(SPE_OFS_ERR_FLAGS, 32'h0400_0000);
    #1 chk({30'h0, pcc, irq}, 32'h0);
    w(SPE_OFS_IRQ_ENABLE, 32'h0);
    $display("phy test done");
  endtask
  task automatic t_regs;
    r(4'hF);
    chk(got, 32'h0);
    w(4'hF, 32'hFFFF_FFFF);
    r(SPE_OFS_ERR_FLAGS);
    chk(got, 32'h0);
    w(SPE_OFS_IRQ_ENABLE, 32'h3);
    @(posedge clock_in);
    ev <= 15'h1;
    @(posedge clock_in);
    ev <= 15'h0;
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    r(SPE_OFS_ERR_FLAGS);
    chk(got, SPE_RST_FLAGS);
    r(SPE_OFS_IRQ_ENABLE);
    chk(got, {30'h0, SPE_RST_IRQ_ENABLE});
    chk({29'h0, pcc, prc, irq}, 32'h0);
    $display("register test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_events();
    t_phy();
    t_regs();
    tally_and_finish();
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish();
  end
endmodule // sata_port_error_status_tb_top

// File: verif/spe_drive_model.sv
// Purpose: far-side drive model for the PHY-ready level
// Assumes: one clock, level starts low
// Notes:   flips the link-up level on request
`timescale 1ns/1ps
module spe_drive_model (
  // Clock and control
  input  wire logic clock_in,
  input  wire logic toggle_in,
  // Link level
  output logic      phy_level_out
);
  initial phy_level_out = 1'b0;
  always @(posedge clock_in) begin
    if (toggle_in) begin
      phy_level_out <= ~phy_level_out;
    end
  end
endmodule // spe_drive_model

// File: verif/spe_error_flags_sva.sv
// Purpose: port checks for the link error flag block
// Assumes: one clock, async active-low reset
// Notes:   bound to every flag block instance
`timescale 1ns/1ps
module spe_error_flags_chk
  import spe_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        phy_link_up_signal_in,
  input wire logic        link_crc_err_in,
  input wire logic        cominit_rx_in,
  input wire logic        mem_abort_in,
  input wire logic        port_link_error_flags_stop_out,
  input wire logic        phy_ready_change_irq_status_out,
  input wire logic        port_connect_change_status_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  wire logic a0  = reg_addr_in == SPE_OFS_ERR_FLAGS;
  wire logic prc = phy_ready_change_irq_status_out;
  wire logic w0  = reg_write_in && a0;
  sequence s_crc; link_crc_err_in ##1 reg_read_in && a0; endsequence
  property p_crc; s_crc |=> reg_rdata_out[SPE_BIT_LINK_CRC]; endproperty
  a_crc: assert property (p_crc) else $error("crc flag missing");
  property p_cmi; cominit_rx_in |=> port_connect_change_status_out; endproperty
  a_cmi: assert property (p_cmi) else $error("connect change missing");
  property p_abt; mem_abort_in |=> port_link_error_flags_stop_out; endproperty
  a_abt: assert property (p_abt) else $error("stop missing");
  property p_w1c;
    w0 && reg_wdata_in[16]
    && ($past(phy_link_up_signal_in, 2) == $past(phy_link_up_signal_in, 3)) |=> !prc;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_w0; w0 && !reg_wdata_in[16] && prc |=> prc; endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared");
  property p_hold; prc && !w0 |=> prc; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_rsv; reg_read_in && a0 |=> (reg_rdata_out & ~SPE_FLAG_MASK) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_irq; irq_out |-> prc || port_connect_change_status_out; endproperty
  a_irq: assert property (p_irq) else $error("irq without status");
  property p_rd0; !reg_read_in |=> reg_rdata_out == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside slot");
endmodule // spe_error_flags_chk
bind spe_error_flags spe_error_flags_chk spe_error_flags_chk_inst (.*);
